//--- logic/ipf_map.vh
/*
  Register map of the peripheral interrupt priority block: byte offsets,
  field positions, bit masks, reset values and the field count.
  Assumes inclusion by the design files of this block only.
*/
`ifndef IPF_MAP_VH
`define IPF_MAP_VH

// Register byte offsets on the APB
`define IPF_OFF_PWM_PAIR_A   12'h000
`define IPF_OFF_PWM_QUAD_B   12'h004
`define IPF_OFF_CMP_PWM      12'h008
`define IPF_OFF_CMP_PAIR     12'h00C
`define IPF_OFF_ADC_LOW      12'h010
`define IPF_OFF_ADC_MID      12'h014

// Field least significant bit positions and field width
`define IPF_FLD_HI           12
`define IPF_FLD_MH           8
`define IPF_FLD_ML           4
`define IPF_FLD_LO           0
`define IPF_FLD_W            3

// Implemented bit masks per register
`define IPF_MASK_PAIR_HIGH   16'h7700
`define IPF_MASK_QUAD        16'h7777
`define IPF_MASK_PAIR_LOW    16'h0077

// Field reset value: priority level 4
`define IPF_PRIO_RESET       3'h4
`define IPF_PRIO_OFF         3'h0

// Number of priority fields
`define IPF_NUM_SRC          18

`endif

//--- logic/ipf_prio_field.v
/*
  One 3-bit priority field with its reset value and write enable.
  Assumes write data already aligned to the field.
*/
`timescale 1ns/10ps
module ipf_prio_field
(
  input  wire       clock,     // System clock
  input  wire       rst_b,     // Async reset, active low
  input  wire       wr_en,     // Write strobe for this field
  input  wire [2:0] wr_data,   // New field value
  output reg  [2:0] prio_r     // Stored priority
);

`include "ipf_map.vh"

  // Loads level 4 at reset, holds until written
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      prio_r <= `IPF_PRIO_RESET; // [RULE4]
    else if (wr_en)
      prio_r <= wr_data; // [RULE4]
  end

endmodule

//--- logic/ipf_src_gate.v
/*
  Per-source request gate: a source asks the arbiter only when its flag
  and enable are set and its priority code is non-zero.
  Assumes flag and enable are synchronous to the clock.
*/
`timescale 1ns/10ps
module ipf_src_gate
(
  input  wire       clock,     // System clock
  input  wire       rst_b,     // Async reset, active low
  input  wire       flag,      // Source event flag
  input  wire       enable,    // Source enable
  input  wire [2:0] prio,      // Field value
  output reg        req_r,     // Request towards arbiter
  output reg  [2:0] level_r    // Priority level towards arbiter
);

`include "ipf_map.vh"

  // Code is the level itself; zero means the source is off
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req_r   <= 1'b0;
      level_r <= `IPF_PRIO_OFF;
    end
    else
    begin
      req_r   <= flag & enable & (prio != `IPF_PRIO_OFF); // [RULE3]
      level_r <= prio; // [RULE1] [RULE2]
    end
  end

endmodule

//--- logic/ipf_prio_top.v
/*
  Peripheral interrupt priority block: six 16-bit registers of 3-bit
  priority fields behind an APB slave, the fields fed to the arbiter.
  Assumes a single clock, APB master synchronous to it, and flag/enable
  inputs from the surrounding interrupt controller.
  Unmapped words answer with an error flag and read as zero.
*/
`timescale 1ns/10ps

// Functional notes
// RULE1 - Field code 7 gives the source priority level 7, the highest.
// RULE2 - Code 1 gives level 1 and every other code gives its binary value.
// RULE3 - Code 0 disables the source so it never requests service.
// RULE4 - Every field resets to level 4 and is readable and writable.
// RULE5 - Unimplemented bits read as zero and ignore writes.
// RULE6 - First PWM register holds gen 2 in 14:12, gen 1 in 10:8, low byte unused.
// RULE7 - Second PWM register holds gens 6, 5, 4, 3 in 14:12, 10:8, 6:4, 2:0.
// RULE8 - Mixed register holds comparator 2, then gens 9, 8, 7 downward.
// RULE9 - Comparator register holds comparator 4 in 6:4 and 3 in 2:0, 15:7 unused.
// RULE10 - First ADC register holds pair 1 in 14:12 and pair 0 in 10:8.
// RULE11 - Second ADC register holds pairs 5, 4, 3, 2 in 14:12, 10:8, 6:4, 2:0.
// RULE12 - Each field drives the arbiter continuously, new value next cycle.
module ipf_prio_top
(
  input  wire        clock,             // System clock, 10 MHz
  input  wire        rst_b,             // Async reset, active low
  input  wire        psel,              // APB select
  input  wire        penable,           // APB access phase
  input  wire        pwrite,            // APB direction, high for write
  input  wire [11:0] paddr,             // APB byte address
  input  wire [31:0] pwdata,            // APB write data
  input  wire [3:0]  pstrb,             // APB byte strobes
  output reg  [31:0] prdata,            // APB read data
  output reg         pready,            // APB ready
  output reg         pslverr,           // APB error on unmapped address
  input  wire [17:0] src_flag,          // Source flags, index order below
  input  wire [17:0] src_enable,        // Source enables
  output wire [17:0] src_req,           // Gated requests to arbiter
  output wire [53:0] src_level,         // Levels to arbiter, 3 bits each
  output wire [2:0]  gen1_pulse_prio,   // Generator 1 priority
  output wire [2:0]  gen2_pulse_prio,   // Generator 2 priority
  output wire [2:0]  gen3_pulse_prio,   // Generator 3 priority
  output wire [2:0]  gen4_pulse_prio,   // Generator 4 priority
  output wire [2:0]  gen5_pulse_prio,   // Generator 5 priority
  output wire [2:0]  gen6_pulse_prio,   // Generator 6 priority
  output wire [2:0]  gen7_pulse_prio,   // Generator 7 priority
  output wire [2:0]  gen8_pulse_prio,   // Generator 8 priority
  output wire [2:0]  gen9_pulse_prio,   // Generator 9 priority
  output wire [2:0]  comparator2_prio,  // Comparator 2 priority
  output wire [2:0]  comparator3_prio,  // Comparator 3 priority
  output wire [2:0]  comparator4_prio,  // Comparator 4 priority
  output wire [2:0]  conv_pair0_prio,   // ADC pair 0 priority
  output wire [2:0]  conv_pair1_prio,   // ADC pair 1 priority
  output wire [2:0]  conv_pair2_prio,   // ADC pair 2 priority
  output wire [2:0]  conv_pair3_prio,   // ADC pair 3 priority
  output wire [2:0]  conv_pair4_prio,   // ADC pair 4 priority
  output wire [2:0]  conv_pair5_prio    // ADC pair 5 priority
);

`include "ipf_map.vh"

  // Register codes of the address decode; code 7 marks a miss
  localparam [2:0] REG_PWM_A = 3'h0;
  localparam [2:0] REG_PWM_B = 3'h1;
  localparam [2:0] REG_CMP_P = 3'h2;
  localparam [2:0] REG_CMP   = 3'h3;
  localparam [2:0] REG_ADC_L = 3'h4;
  localparam [2:0] REG_ADC_M = 3'h5;
  localparam [2:0] REG_NONE  = 3'h7;

  // Source index order: gens 1..9 (0..8), comparators 2..4 (9..11),
  // ADC pairs 0..5 (12..17).
  // Register index and field slot per source; slot 3 = bits 14:12,
  // 2 = 10:8, 1 = 6:4, 0 = 2:0.
  function [2:0] src_reg;
    input integer s;
    begin
      case (s)
        0:       src_reg = REG_PWM_A; // [RULE6] gen 1
        1:       src_reg = REG_PWM_A; // [RULE6] gen 2
        2:       src_reg = REG_PWM_B; // [RULE7] gen 3
        3:       src_reg = REG_PWM_B; // [RULE7] gen 4
        4:       src_reg = REG_PWM_B; // [RULE7] gen 5
        5:       src_reg = REG_PWM_B; // [RULE7] gen 6
        6:       src_reg = REG_CMP_P; // [RULE8] gen 7
        7:       src_reg = REG_CMP_P; // [RULE8] gen 8
        8:       src_reg = REG_CMP_P; // [RULE8] gen 9
        9:       src_reg = REG_CMP_P; // [RULE8] comparator 2
        10:      src_reg = REG_CMP;   // [RULE9] comparator 3
        11:      src_reg = REG_CMP;   // [RULE9] comparator 4
        12:      src_reg = REG_ADC_L; // [RULE10] pair 0
        13:      src_reg = REG_ADC_L; // [RULE10] pair 1
        14:      src_reg = REG_ADC_M; // [RULE11] pair 2
        15:      src_reg = REG_ADC_M; // [RULE11] pair 3
        16:      src_reg = REG_ADC_M; // [RULE11] pair 4
        default: src_reg = REG_ADC_M; // [RULE11] pair 5
      endcase
    end
  endfunction

  function [1:0] src_slot;
    input integer s;
    begin
      case (s)
        0:       src_slot = 2'h2; // gen 1 in 10:8
        1:       src_slot = 2'h3; // gen 2 in 14:12
        2:       src_slot = 2'h0; // gen 3
        3:       src_slot = 2'h1; // gen 4
        4:       src_slot = 2'h2; // gen 5
        5:       src_slot = 2'h3; // gen 6
        6:       src_slot = 2'h0; // gen 7
        7:       src_slot = 2'h1; // gen 8
        8:       src_slot = 2'h2; // gen 9
        9:       src_slot = 2'h3; // comparator 2
        10:      src_slot = 2'h0; // comparator 3
        11:      src_slot = 2'h1; // comparator 4
        12:      src_slot = 2'h2; // pair 0
        13:      src_slot = 2'h3; // pair 1
        14:      src_slot = 2'h0; // pair 2
        15:      src_slot = 2'h1; // pair 3
        16:      src_slot = 2'h2; // pair 4
        default: src_slot = 2'h3; // pair 5
      endcase
    end
  endfunction

  // Address decode, shared by write and read paths
  function [2:0] addr_reg;
    input [11:0] a;
    begin
      case (a)
        `IPF_OFF_PWM_PAIR_A: addr_reg = REG_PWM_A;
        `IPF_OFF_PWM_QUAD_B: addr_reg = REG_PWM_B;
        `IPF_OFF_CMP_PWM:    addr_reg = REG_CMP_P;
        `IPF_OFF_CMP_PAIR:   addr_reg = REG_CMP;
        `IPF_OFF_ADC_LOW:    addr_reg = REG_ADC_L;
        `IPF_OFF_ADC_MID:    addr_reg = REG_ADC_M;
        default:             addr_reg = REG_NONE;
      endcase
    end
  endfunction

  wire [2:0]  acc_reg = addr_reg(paddr);
  wire        acc_hit = (acc_reg != REG_NONE);
  // Writes take effect at the edge that closes the ready cycle, after the wait state
  wire        acc_go  = psel & penable & pready;
  wire [53:0] prio_bus;
  wire [5:0]  reg_wr;

  // One write select per register, shared by all of its fields
  genvar r;
  generate
    for (r = 0; r < 6; r = r + 1)
    begin : gen_reg
      assign reg_wr[r] = acc_go & pwrite & acc_hit & (acc_reg == r);
    end
  endgenerate

  // One field flop and one request gate per source
  genvar g;
  generate
    for (g = 0; g < `IPF_NUM_SRC; g = g + 1)
    begin : gen_src
      localparam [1:0] SLOT = src_slot(g);
      localparam [2:0] REGN = src_reg(g);
      localparam       LSB  = SLOT * 4;
      wire       fld_we;
      wire [2:0] fld_wd;

      // Byte strobe of the lane that holds this field
      assign fld_we = reg_wr[REGN]
                      & pstrb[LSB / 8];
      // Field data from the same lane, lined up to bit 0
      assign fld_wd = pwdata[LSB +: `IPF_FLD_W];

      ipf_prio_field u_field
      (
        .clock   (clock),
        .rst_b   (rst_b),
        .wr_en   (fld_we),
        .wr_data (fld_wd),
        .prio_r  (prio_bus[g*3 +: 3])
      );

      ipf_src_gate u_gate
      (
        .clock   (clock),
        .rst_b   (rst_b),
        .flag    (src_flag[g]),
        .enable  (src_enable[g]),
        .prio    (prio_bus[g*3 +: 3]),
        .req_r   (src_req[g]),
        .level_r (src_level[g*3 +: 3])
      );
    end
  endgenerate

  // Field values straight from their flops to the arbiter
  assign gen1_pulse_prio  = prio_bus[2:0];   // [RULE12]
  assign gen2_pulse_prio  = prio_bus[5:3];
  assign gen3_pulse_prio  = prio_bus[8:6];
  assign gen4_pulse_prio  = prio_bus[11:9];
  assign gen5_pulse_prio  = prio_bus[14:12];
  assign gen6_pulse_prio  = prio_bus[17:15];
  assign gen7_pulse_prio  = prio_bus[20:18];
  assign gen8_pulse_prio  = prio_bus[23:21];
  assign gen9_pulse_prio  = prio_bus[26:24];

  // Comparator fields
  assign comparator2_prio = prio_bus[29:27];
  assign comparator3_prio = prio_bus[32:30];
  assign comparator4_prio = prio_bus[35:33];

  // ADC pair fields
  assign conv_pair0_prio  = prio_bus[38:36];
  assign conv_pair1_prio  = prio_bus[41:39];
  assign conv_pair2_prio  = prio_bus[44:42];
  assign conv_pair3_prio  = prio_bus[47:45];
  assign conv_pair4_prio  = prio_bus[50:48];
  assign conv_pair5_prio  = prio_bus[53:51];

  // Register images; unused bits are hard zero, so writes there vanish.
  // First PWM register: generators 2 and 1, low byte unused
  wire [15:0] img_pwm_a = {1'b0, gen2_pulse_prio,
                           1'b0, gen1_pulse_prio,
                           8'h00}; // [RULE5] [RULE6]

  // Second PWM register: generators 6 down to 3
  wire [15:0] img_pwm_b = {1'b0, gen6_pulse_prio,
                           1'b0, gen5_pulse_prio,
                           1'b0, gen4_pulse_prio,
                           1'b0, gen3_pulse_prio}; // [RULE7]

  // Mixed register: comparator 2 over generators 9 down to 7
  wire [15:0] img_cmp_p = {1'b0, comparator2_prio,
                           1'b0, gen9_pulse_prio,
                           1'b0, gen8_pulse_prio,
                           1'b0, gen7_pulse_prio}; // [RULE8]

  // Comparator register: comparators 4 and 3 in the low byte only
  wire [15:0] img_cmp   = {9'h000, comparator4_prio,
                           1'b0, comparator3_prio}; // [RULE9]

  // First ADC register: pairs 1 and 0, low byte unused
  wire [15:0] img_adc_l = {1'b0, conv_pair1_prio,
                           1'b0, conv_pair0_prio,
                           8'h00}; // [RULE10]

  // Second ADC register: pairs 5 down to 2
  wire [15:0] img_adc_m = {1'b0, conv_pair5_prio,
                           1'b0, conv_pair4_prio,
                           1'b0, conv_pair3_prio,
                           1'b0, conv_pair2_prio}; // [RULE11]

  reg [15:0] rd_img;

  // Read mux; reserved bits and unmapped space read as zero
  always @*
  begin
    case (acc_reg)
      REG_PWM_A: rd_img = img_pwm_a & `IPF_MASK_PAIR_HIGH; // [RULE5]
      REG_PWM_B: rd_img = img_pwm_b & `IPF_MASK_QUAD;
      REG_CMP_P: rd_img = img_cmp_p & `IPF_MASK_QUAD;
      REG_CMP:   rd_img = img_cmp & `IPF_MASK_PAIR_LOW;
      REG_ADC_L: rd_img = img_adc_l & `IPF_MASK_PAIR_HIGH;
      REG_ADC_M: rd_img = img_adc_m & `IPF_MASK_QUAD;
      default:   rd_img = 16'h0000;
    endcase
  end

  // APB answer: one wait state so every output comes from a flop.
  // pready rises after the first access cycle and drops one cycle later.
  wire        acc_first = psel & penable & !pready;

  // Ready pulse; with psel and penable held it repeats every other cycle
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      pready <= 1'b0;
    else
      pready <= acc_first;
  end

  // Read data stands only in the ready cycle, zero otherwise
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      prdata <= 32'h0000_0000;
    else if (acc_first & !pwrite)
      prdata <= {16'h0000, rd_img};
    else
      prdata <= 32'h0000_0000;
  end

  // Error flag for a miss, only alongside the ready pulse
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      pslverr <= 1'b0;
    else
      pslverr <= acc_first & ~acc_hit;
  end

endmodule

//--- verification/ipf_prio_checker.sv
/*
  Checker for the priority field block: APB timing, field mapping, arbiter view.
  Assumes the top module's port names; bound onto every instance of it.
*/
`timescale 1ns/10ps
module ipf_prio_checker
(
  input logic        clock,            // System clock
  input logic        rst_b,            // Async reset, active low
  input logic        psel,             // APB select
  input logic        penable,          // APB access phase
  input logic        pwrite,           // APB direction
  input logic [11:0] paddr,            // APB address
  input logic [31:0] pwdata,           // APB write data
  input logic [3:0]  pstrb,            // APB strobes
  input logic [31:0] prdata,           // APB read data
  input logic        pready,           // APB ready
  input logic [17:0] src_flag,         // Source flags
  input logic [17:0] src_enable,       // Source enables
  input logic [17:0] src_req,          // Gated requests
  input logic [53:0] src_level,        // Arbiter levels
  input logic [2:0]  gen1_pulse_prio,  // Generator 1 field
  input logic [2:0]  gen2_pulse_prio,  // Generator 2 field
  input logic [2:0]  gen3_pulse_prio,  // Generator 3 field
  input logic [2:0]  gen4_pulse_prio,  // Generator 4 field
  input logic [2:0]  comparator3_prio, // Comparator 3 field
  input logic [2:0]  comparator4_prio, // Comparator 4 field
  input logic [2:0]  conv_pair2_prio,  // Pair 2 field
  input logic [2:0]  conv_pair3_prio,  // Pair 3 field
  input logic [2:0]  conv_pair4_prio,  // Pair 4 field
  input logic [2:0]  conv_pair5_prio   // Pair 5 field
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Completed transfers and field slices of the write word
  wire       wr_hit = psel && penable && pready && pwrite;
  wire       rd_hit = psel && penable && pready && !pwrite;
  wire [2:0] w_hi   = pwdata[14:12];
  wire [2:0] w_mh   = pwdata[10:8];
  wire [2:0] w_ml   = pwdata[6:4];
  wire [2:0] w_lo   = pwdata[2:0];

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held beyond one cycle");
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing one cycle into access");
  pad_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000 && !prdata[15] &&
    !prdata[11] && !prdata[7] && !prdata[3]) else $error("unused read bit set");
  pair_a_wr_a: assert property (wr_hit && paddr == 12'h000 && pstrb[1] |=>
    gen2_pulse_prio == $past(w_hi) && gen1_pulse_prio == $past(w_mh))
    else $error("first pwm register field wrong");
  quad_wr_a: assert property (wr_hit && paddr == 12'h004 && pstrb[0] |=>
    gen4_pulse_prio == $past(w_ml) && gen3_pulse_prio == $past(w_lo))
    else $error("second pwm register field wrong");
  cmp_wr_a: assert property (wr_hit && paddr == 12'h00C && pstrb[0] |=>
    comparator4_prio == $past(w_ml) && comparator3_prio == $past(w_lo))
    else $error("comparator field wrong");
  adc_rd_a: assert property (rd_hit && paddr == 12'h014 |-> prdata[15:0] ==
    {1'b0, conv_pair5_prio, 1'b0, conv_pair4_prio, 1'b0, conv_pair3_prio, 1'b0, conv_pair2_prio})
    else $error("pair register read wrong");
  level_follow_a: assert property (1'b1 |=> src_level[44:42] == $past(conv_pair2_prio))
    else $error("arbiter level lags field");
  off_block_a: assert property (conv_pair2_prio == 3'h0 |=> !src_req[14])
    else $error("disabled source requested");
  req_pass_a: assert property (src_flag[14] && src_enable[14] && conv_pair2_prio != 3'h0
    |=> src_req[14]) else $error("enabled source not requested");

  cover property (wr_hit);
  cover property (rd_hit && paddr == 12'h014);
  cover property (src_req[14] && src_level[44:42] == 3'h7);
endmodule

bind ipf_prio_top ipf_prio_checker ipf_prio_checker_i
(
  .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .src_flag(src_flag), .src_enable(src_enable), .src_req(src_req), .src_level(src_level),
  .gen1_pulse_prio(gen1_pulse_prio), .gen2_pulse_prio(gen2_pulse_prio),
  .gen3_pulse_prio(gen3_pulse_prio), .gen4_pulse_prio(gen4_pulse_prio),
  .comparator3_prio(comparator3_prio), .comparator4_prio(comparator4_prio),
  .conv_pair2_prio(conv_pair2_prio), .conv_pair3_prio(conv_pair3_prio),
  .conv_pair4_prio(conv_pair4_prio), .conv_pair5_prio(conv_pair5_prio)
);

//--- verification/ipf_src_model.sv
/*
  Model of the peripheral sources: flags and enables launched on the clock.
  Assumes the bench sets the wanted pattern; sources stay quiet in reset.
*/
`timescale 1ns/10ps
module ipf_src_model
(
  input  logic        clock,      // System clock
  input  logic        rst_b,      // Async reset, active low
  input  logic [17:0] want_flag,  // Flags the bench asks for
  input  logic [17:0] want_en,    // Enables the bench asks for
  output logic [17:0] src_flag,   // Flags to the block
  output logic [17:0] src_enable  // Enables to the block
);
  // Registered so the block sees clean synchronous sources
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      src_flag   <= 18'h00000;
      src_enable <= 18'h00000;
    end
    else
    begin
      src_flag   <= want_flag;
      src_enable <= want_en;
    end
  end
endmodule

//--- verification/tb_ipf_prio_top.sv
/*
  Self-checking bench for the priority field block over APB.
  Assumes one 10 MHz clock and the source model on the request side.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_ipf_prio_top;
  logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [3:0]  pstrb;
  logic [17:0] src_flag, src_enable, src_req, want_flag, want_en;
  logic [53:0] src_level;
  wire  [2:0]  pr [0:17];
  int          err_total, comparisons;
  logic [15:0] rst_v [6] = '{16'h4400, 16'h4444, 16'h4444, 16'h0044, 16'h4400, 16'h4444};
  logic [15:0] msk [6]   = '{16'h7700, 16'h7777, 16'h7777, 16'h0077, 16'h7700, 16'h7777};
  logic [15:0] mapv [6]  = '{16'h3200, 16'h6543, 16'h2175, 16'h0065, 16'h1700, 16'h4321};
  logic [2:0]  mapf [18] = '{2, 3, 3, 4, 5, 6, 5, 7, 1, 2, 5, 6, 7, 1, 1, 2, 3, 4};

  ipf_src_model ipf_src_model_i (.clock(clock), .rst_b(rst_b), .want_flag(want_flag),
    .want_en(want_en), .src_flag(src_flag), .src_enable(src_enable));
  ipf_prio_top ipf_prio_top_i (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_flag(src_flag), .src_enable(src_enable),
    .src_req(src_req), .src_level(src_level), .gen1_pulse_prio(pr[0]),
    .gen2_pulse_prio(pr[1]), .gen3_pulse_prio(pr[2]), .gen4_pulse_prio(pr[3]),
    .gen5_pulse_prio(pr[4]), .gen6_pulse_prio(pr[5]), .gen7_pulse_prio(pr[6]),
    .gen8_pulse_prio(pr[7]), .gen9_pulse_prio(pr[8]), .comparator2_prio(pr[9]),
    .comparator3_prio(pr[10]), .comparator4_prio(pr[11]), .conv_pair0_prio(pr[12]),
    .conv_pair1_prio(pr[13]), .conv_pair2_prio(pr[14]), .conv_pair3_prio(pr[15]),
    .conv_pair4_prio(pr[16]), .conv_pair5_prio(pr[17]));

  // Free-running 100 ns clock
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task close_out;
    if (err_total == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One APB transfer; the wait is bounded so a dead slave cannot hang the run
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      err_total++;
      close_out();
    end
  endtask

  task t_reset;
    for (int i = 0; i < 6; i++)
    begin
      apb(12'(4 * i), 1'b0, 32'h0, 4'hF);
      `CHK("reset read", {16'h0000, rst_v[i]}, rd_q)
    end
    for (int i = 0; i < 18; i++) `CHK("reset field", 3'h4, pr[i])
  endtask

  // All ones everywhere: only the field bits may stick
  task t_ones;
    for (int i = 0; i < 6; i++)
    begin
      apb(12'(4 * i), 1'b1, 32'hFFFF_FFFF, 4'hF);
      apb(12'(4 * i), 1'b0, 32'h0, 4'hF);
      `CHK("ones read", {16'h0000, msk[i]}, rd_q)
    end
    @(negedge clock);
    for (int i = 0; i < 18; i++) `CHK("ones field", 3'h7, pr[i])
  endtask

  task t_map;
    for (int i = 0; i < 6; i++) apb(12'(4 * i), 1'b1, {16'h0000, mapv[i]}, 4'h3);
    @(posedge clock);
    @(negedge clock);
    for (int i = 0; i < 18; i++)
      `CHK("map field", mapf[i], pr[i])
    for (int i = 0; i < 18; i++)
      `CHK("map level", mapf[i], src_level[3*i +: 3])
    `CHK("map request", 18'h3FFFF, src_req)
  endtask

  // Every code on pair 2, seen by the arbiter one cycle after the field
  task t_codes;
    for (int c = 0; c < 8; c++)
    begin
      apb(12'h014, 1'b1, {16'h0000, {4{1'b0, 3'(c)}}}, 4'h3);
      @(posedge clock);
      @(negedge clock);
      `CHK("code field", 3'(c), pr[14])
      `CHK("code level", 3'(c), src_level[44:42])
      `CHK("code request", (c != 0), src_req[14])
    end
  endtask

  // Byte strobes, pad bits and an unmapped word
  task t_strobe;
    apb(12'h004, 1'b1, 32'h0000_1111, 4'h1);
    apb(12'h004, 1'b0, 32'h0, 4'hF);
    `CHK("strobe low", 32'h0000_6511, rd_q)
    apb(12'h000, 1'b1, 32'h0000_45FF, 4'h2);
    apb(12'h000, 1'b0, 32'h0, 4'hF);
    `CHK("pad ignore", 32'h0000_4500, rd_q)
    apb(12'h018, 1'b0, 32'h0, 4'hF);
    `CHK("unmapped data", 32'h0, rd_q)
    `CHK("unmapped err", 1'b1, err_q)
  endtask

  // Main sequence: reset for five cycles, then each scenario in turn
  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    want_flag = 18'h3FFFF;
    want_en = 18'h3FFFF;
    err_total = 0;
    comparisons = 0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    t_reset();
    t_ones();
    t_map();
    t_codes();
    t_strobe();
    close_out();
  end
endmodule
